// ### core/bpp_host.sv
// Host controller that reads and programs a 2048 x 4 one-time bipolar PROM.
// Assumes pin inputs synchronous to clk; the analogue pulse source and sense
// comparator are external, switched by prog_drive and sense_en.
`timescale 1ns/100ps
`default_nettype none
module bpp_host
    import bpp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              cmd_read,
    input  wire logic              cmd_prog,
    input  wire logic              fast_family,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [BIT_W-1:0]  cmd_bit,
    input  wire logic [DATA_W-1:0] prom_data_in,
    input  wire logic              sense_high,
    output logic [ADDR_W-1:0]      prom_addr,
    output logic                   prom_select_n,
    output logic [DATA_W-1:0]      prog_drive,
    output logic                   sense_en,
    output logic                   busy,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   prog_done,
    output logic                   prog_fail
);
    typedef struct packed {
        bpp_state_e        st;
        logic [ADDR_W-1:0] addr;
        logic              sel_n;
        logic [BIT_W-1:0]  bitsel;
        logic [DATA_W-1:0] drive;
        logic              sense;
        logic              seen_one;
        logic [2:0]        extra;
        logic [PCNT_W-1:0] pulses;
        logic              fail;
        logic              busy;
        logic              rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic              done;
        logic              tload;
        logic [CNT_W-1:0]  tcount;
    } bpp_host_s;
    bpp_host_s r;
    bpp_host_s next_r;
    logic      t_done;

    // One-hot drive mask so only a single output carries current
    function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] b);
        bit_mask = DATA_W'(1) << b;
    endfunction

    bpp_cycle_timer u_tmr (
        .clk   (clk),
        .nrst  (nrst),
        .load  (r.tload),
        .count (r.tcount),
        .done  (t_done)
    );

    // ************************************************
    // Sequencer
    // ************************************************
    always_comb begin
        next_r = r;
        next_r.tload = 1'b0;
        next_r.rd_valid = 1'b0;
        next_r.done = 1'b0;
        case (r.st)
            ST_IDLE: begin
                next_r.busy = 1'b0;
                next_r.sel_n = 1'b1;
                next_r.drive = ERASED_WORD;
                next_r.sense = 1'b0;
                if (cmd_prog) begin
                    // Address first; select already high keeps part disabled
                    next_r.addr = cmd_addr;
                    next_r.bitsel = cmd_bit;
                    next_r.pulses = '0;
                    next_r.seen_one = 1'b0;
                    next_r.fail = 1'b0;
                    next_r.extra = fast_family ? EXTRA_FAST : EXTRA_STD;
                    next_r.busy = 1'b1;
                    next_r.tload = 1'b1;
                    next_r.tcount = CNT_W'(ADDR_GAP_CYC);
                    next_r.st = ST_ASETUP;
                end else if (cmd_read) begin
                    next_r.addr = cmd_addr;
                    next_r.sel_n = 1'b0;
                    next_r.busy = 1'b1;
                    next_r.tload = 1'b1;
                    next_r.tcount = CNT_W'(1);
                    next_r.st = ST_READ;
                end
            end
            ST_READ: begin
                if (t_done) begin
                    next_r.st = ST_RDONE;
                end
            end
            ST_RDONE: begin
                // Access time is tens of ns, well inside the four cycles waited
                next_r.rd_data = prom_data_in;
                next_r.rd_valid = 1'b1;
                next_r.sel_n = 1'b1;
                next_r.st = ST_IDLE;
            end
            ST_ASETUP: begin
                if (t_done) begin
                    next_r.drive = bit_mask(r.bitsel);
                    next_r.pulses = r.pulses + PCNT_W'(1);
                    next_r.tload = 1'b1;
                    next_r.tcount = CNT_W'(PW_CYC);
                    next_r.st = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (t_done) begin
                    next_r.drive = ERASED_WORD;
                    next_r.tload = 1'b1;
                    next_r.tcount = CNT_W'(SENSE_DLY_CYC);
                    next_r.st = ST_SDLY;
                end
            end
            ST_SDLY: begin
                next_r.sense = 1'b1;
                if (t_done) begin
                    next_r.tload = 1'b1;
                    next_r.tcount = CNT_W'(OFF_CYC);
                    next_r.st = ST_OFF;
                    if (r.seen_one) begin
                        next_r.extra = r.extra - 3'h1;
                    end else if (sense_high) begin
                        // Sensed one; bits only go from zero to one
                        next_r.seen_one = 1'b1;
                    end
                end
            end
            ST_OFF: begin
                if (t_done) begin
                    next_r.tload = 1'b1;
                    if (r.seen_one && r.extra == 3'h0) begin
                        next_r.sense = 1'b0;
                        next_r.tcount = CNT_W'(ADDR_GAP_CYC);
                        next_r.st = ST_AHOLD;
                    end else if (!r.seen_one && r.pulses >= PULSE_LIMIT) begin
                        next_r.fail = 1'b1;
                        next_r.sense = 1'b0;
                        next_r.tcount = CNT_W'(ADDR_GAP_CYC);
                        next_r.st = ST_AHOLD;
                    end else begin
                        next_r.sense = 1'b0;
                        next_r.drive = bit_mask(r.bitsel);
                        next_r.pulses = r.pulses + PCNT_W'(1);
                        next_r.tcount = CNT_W'(PW_CYC);
                        next_r.st = ST_PULSE;
                    end
                end
            end
            ST_AHOLD: begin
                if (t_done) begin
                    next_r.done = 1'b1;
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.sel_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign prom_addr     = r.addr;
    assign prom_select_n = r.sel_n;
    assign prog_drive    = r.drive;
    assign sense_en      = r.sense;
    assign busy          = r.busy;
    assign rd_valid      = r.rd_valid;
    assign rd_data       = r.rd_data;
    assign prog_done     = r.done;
    assign prog_fail     = r.fail;
endmodule // bpp_host
`default_nettype wire

// ### inc/bpp_pkg.sv
// Constants for the bipolar PROM programming host.
// Assumes a 125 MHz system clock; all timing counts derive from it.
package bpp_pkg;
    localparam int CLK_MHZ        = 125;
    localparam int ADDR_W         = 11;
    localparam int DATA_W         = 4;
    localparam int BIT_W          = 2;
    localparam int CNT_W          = 14;
    localparam int PCNT_W         = 14;
    // Times in nanoseconds, duty figure in percent
    localparam int PW_MIN_NS      = 7100;
    localparam int PW_MAX_NS      = 7900;
    localparam int PW_NOM_NS      = 7500;
    localparam int SENSE_DLY_NS   = 700;
    localparam int ADDR_GAP_NS    = 10000;
    localparam int DUTY_PCT       = 70;
    // Cycle counts, nominal pulse width and least delays rounded up
    localparam int PW_CYC         = (PW_NOM_NS * CLK_MHZ + 999) / 1000;
    localparam int SENSE_DLY_CYC  = (SENSE_DLY_NS * CLK_MHZ + 999) / 1000;
    localparam int ADDR_GAP_CYC   = (ADDR_GAP_NS * CLK_MHZ + 999) / 1000;
    // Each timed phase lasts its count plus this many cycles of load and done
    localparam int TMR_LAT        = 2;
    // Off time so that the on share stays at or above the duty figure;
    // the sense delay and both phase latencies come out of the same gap
    localparam int OFF_CYC        = ((PW_CYC + TMR_LAT) * (100 - DUTY_PCT)) / DUTY_PCT
                                    - SENSE_DLY_CYC - 2 * TMR_LAT;
    localparam logic [2:0] EXTRA_STD = 3'h4;
    localparam logic [2:0] EXTRA_FAST = 3'h1;
    localparam logic [PCNT_W-1:0] PULSE_LIMIT = 14'h2710;
    localparam logic [DATA_W-1:0] ERASED_WORD = 4'h0;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_ASETUP = 8'h02,
        ST_PULSE  = 8'h04,
        ST_SDLY   = 8'h08,
        ST_OFF    = 8'h10,
        ST_AHOLD  = 8'h20,
        ST_READ   = 8'h40,
        ST_RDONE  = 8'h80
    } bpp_state_e;
endpackage

// ### core/bpp_cycle_timer.sv
// Down-counting delay timer with a one-cycle done pulse.
// Assumes load has priority over counting.
`timescale 1ns/100ps
`default_nettype none
module bpp_cycle_timer
    import bpp_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    output logic                  done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic             done;
    } bpp_tmr_s;
    bpp_tmr_s r;
    bpp_tmr_s next_r;
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (load) begin
            next_r.cnt = count;
            next_r.run = 1'b1;
        end else if (r.run) begin
            if (r.cnt <= CNT_W'(1)) begin
                next_r.run = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.cnt = r.cnt - CNT_W'(1);
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign done = r.done;
endmodule // bpp_cycle_timer
`default_nettype wire

// ### verification/bpp_prom_model.sv
// Behavioural 2048 x 4 one-time PROM on the host's pins.
// Assumes the host paces pulses; bits set after SET_PULSES pulses.
`timescale 1ns/100ps
`default_nettype none
module bpp_prom_model
    import bpp_pkg::*;
#(
    parameter int SET_PULSES = 2
)
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              select_n,
    input  wire logic [DATA_W-1:0] drive,
    input  wire logic              sense_en,
    output logic [DATA_W-1:0]      data,
    output logic                   sense_high
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last = 4'h0;
    int                hits = 0;
    initial foreach (mem[i]) mem[i] = 4'h0;
    // Pulses only count with the part deselected
    always @(posedge (|drive)) begin
        if (select_n && $countones(drive) == 1) begin
            hits = (drive == last) ? hits + 1 : 1;
            last = drive;
            if (hits >= SET_PULSES) mem[addr] = mem[addr] | drive;
        end
    end
    // Released open-collector lines float up
    assign data = select_n ? 4'hf : mem[addr];
    assign sense_high = sense_en && ((mem[addr] & last) != 4'h0);
endmodule // bpp_prom_model
`default_nettype wire

// ### verification/bpp_host_monitor.sv
// Checker for the PROM host pin timing and read handshake.
// Assumes binding onto bpp_host; one clock, nrst synchronous.
`timescale 1ns/100ps
`default_nettype none
module bpp_host_monitor
    import bpp_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              cmd_read,
    input wire logic              cmd_prog,
    input wire logic              busy,
    input wire logic              rd_valid,
    input wire logic [ADDR_W-1:0] prom_addr,
    input wire logic              prom_select_n,
    input wire logic [DATA_W-1:0] prog_drive,
    input wire logic              sense_en
);
    // 10 us, 7.1 us and 7.9 us at 8 ns
    localparam int GAP = 1250;
    localparam int PW_LO = 888;
    localparam int PW_HI = 987;
    logic [13:0] pw;
    logic [13:0] age;
    logic [13:0] quiet;
    logic [13:0] gap;
    logic [13:0] last_pw;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Ages saturate so long idles never wrap
    always_ff @(posedge clk) begin
        pw <= (!nrst || prog_drive == 4'h0) ? 14'h0 : pw + 14'h1;
        age <= !nrst ? 14'h3fff : $changed(prom_addr) ? 14'h0 : age + {13'h0, ~&age};
        quiet <= !nrst ? 14'h3fff : sense_en ? 14'h0 : quiet + {13'h0, ~&quiet};
        gap <= !nrst ? 14'h3fff : (prog_drive != 4'h0) ? 14'h0 : gap + {13'h0, ~&gap};
        last_pw <= !nrst ? 14'h0 : $fell(|prog_drive) ? pw : last_pw;
    end
    sequence s_take_read;
        cmd_read && !cmd_prog && !busy;
    endsequence
    sequence s_read_walk;
        !prom_select_n [*4] ##1 (rd_valid && prom_select_n);
    endsequence
    a_read_walk: assert property (s_take_read |=> s_read_walk)
        else $error("read walk wrong");
    a_pulse_deselected: assert property ((prog_drive != 4'h0) |-> prom_select_n)
        else $error("pulse with part selected");
    a_one_bit: assert property ($onehot0(prog_drive))
        else $error("several outputs pulsed");
    a_pulse_width: assert property ($fell(|prog_drive) |-> pw >= PW_LO && pw <= PW_HI)
        else $error("pulse width out of range");
    a_addr_setup: assert property ($rose(|prog_drive) |-> age >= GAP)
        else $error("address setup short");
    a_addr_hold: assert property ($changed(prom_addr) |-> gap >= GAP)
        else $error("address hold short");
    a_sense_before: assert property ($changed(prom_addr) |-> quiet >= GAP)
        else $error("sense on before address change");
    a_sense_after: assert property (sense_en |-> age >= GAP)
        else $error("sense on after address change");
    a_no_sense_pulse: assert property ((prog_drive != 4'h0) |-> !sense_en)
        else $error("sense during pulse");
    // Only gaps inside one pulse train count; setup gaps are far longer
    a_duty_cycle: assert property (($rose(|prog_drive) && gap < GAP) |->
        (gap * DUTY_PCT) <= (last_pw * (100 - DUTY_PCT)))
        else $error("pulse train duty too low");
endmodule // bpp_host_monitor
bind bpp_host bpp_host_monitor u_bpp_host_monitor (.clk(clk), .nrst(nrst), .cmd_read(cmd_read),
    .cmd_prog(cmd_prog), .busy(busy), .rd_valid(rd_valid), .prom_addr(prom_addr),
    .prom_select_n(prom_select_n), .prog_drive(prog_drive), .sense_en(sense_en));
`default_nettype wire

// ### verification/bpp_host_bench.sv
// Self-checking bench: host reads and programs a behavioural PROM.
// Assumes 125 MHz clock; model sets a bit on its second pulse.
`timescale 1ns/100ps
`default_nettype none
module bpp_host_bench;
    import bpp_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, cmd_read = 1'b0, cmd_prog = 1'b0, fast_family = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = '0, prom_addr;
    logic [BIT_W-1:0] cmd_bit = '0;
    logic [DATA_W-1:0] prom_data_in, prog_drive, rd_data;
    logic prom_select_n, sense_high, sense_en, busy, rd_valid, prog_done, prog_fail, drv_q;
    int failures = 0, tests_run = 0, pulses = 0, cycles = 0;
    bpp_host u_bpp_host (.clk(clk), .nrst(nrst), .cmd_read(cmd_read), .cmd_prog(cmd_prog),
        .fast_family(fast_family), .cmd_addr(cmd_addr), .cmd_bit(cmd_bit),
        .prom_data_in(prom_data_in), .sense_high(sense_high), .prom_addr(prom_addr),
        .prom_select_n(prom_select_n), .prog_drive(prog_drive), .sense_en(sense_en),
        .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .prog_done(prog_done),
        .prog_fail(prog_fail));
    bpp_prom_model #(.SET_PULSES(2)) u_bpp_prom_model (.addr(prom_addr), .select_n(prom_select_n),
        .drive(prog_drive), .sense_en(sense_en), .data(prom_data_in), .sense_high(sense_high));
    initial forever #4 clk = ~clk;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard well above the ~17k cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (|prog_drive && !drv_q) pulses++;
        drv_q = |prog_drive;
        if (cycles == 40000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(negedge clk);
        cmd_read = 1'b1;
        cmd_addr = a;
        @(negedge clk);
        cmd_read = 1'b0;
        for (int n = 0; n < 8 && rd_valid !== 1'b1; n++) @(negedge clk);
        check("rd_valid", rd_valid, 1'b1);
        check("rd_data", rd_data, exp);
        check("select_n", prom_select_n, 1'b1);
    endtask
    task automatic do_prog(input logic fast, input logic [ADDR_W-1:0] a, input logic [BIT_W-1:0] b,
        input int exp_pulses);
        pulses = 0;
        @(negedge clk);
        cmd_prog = 1'b1;
        fast_family = fast;
        cmd_addr = a;
        cmd_bit = b;
        @(negedge clk);
        cmd_prog = 1'b0;
        for (int n = 0; n < 30000 && prog_done !== 1'b1; n++) @(negedge clk);
        check("prog_done", prog_done, 1'b1);
        check("prog_fail", prog_fail, 1'b0);
        check("pulses", 16'(pulses), 16'(exp_pulses));
    endtask
    task automatic t_reset();
        check("idle select_n", prom_select_n, 1'b1);
        check("idle drive", prog_drive, 4'h0);
        $display("reset test done");
    endtask
    task automatic t_erased();
        do_read(11'h7ff, 4'h0);
        do_read(11'h000, 4'h0);
        $display("erased read test done");
    endtask
    task automatic t_fast();
        do_prog(1'b1, 11'h123, 2'h2, 3);
        do_read(11'h123, 4'h4);
        do_read(11'h124, 4'h0);
        $display("fast program test done");
    endtask
    task automatic t_std();
        do_prog(1'b0, 11'h123, 2'h0, 6);
        do_read(11'h123, 4'h5);
        $display("standard program test done");
    endtask
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_erased();
        t_fast();
        t_std();
        report_and_stop();
    end
endmodule // bpp_host_bench
`default_nettype wire
